/* File: rtl/tmam_top.sv */
// Thermal monitor, threshold flags and analog mux select control.
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ps
`include "tmam_defs.svh"

module tmam_top #(
  parameter int SAMPLE_INTERVAL_CYC = `TMAM_SAMPLE_INTERVAL_CYC,
  parameter int SAMPLE_WINDOW_CYC = `TMAM_SAMPLE_WINDOW_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [7:0] temp_center,
  input wire logic run_state,
  input wire logic standby_state,
  input wire logic system_on,
  input wire logic [5:0] switcher_at_1v8,
  output logic irq,
  output logic thermal_shutdown,
  output logic monitor_power,
  output logic analog_mux_drive,
  output logic analog_mux_pulldown,
  output logic [4:0] analog_mux_source,
  output logic analog_mux_div_125
);
  import tmam_pkg::*;

  // ----------------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------------
  // Trip point of comparator k; index 6 is the shutdown comparator.
  function automatic logic [7:0] thr_of(input int k);
    case (k)
      0: thr_of = `TMAM_THR_80;
      1: thr_of = `TMAM_THR_95;
      2: thr_of = `TMAM_THR_110;
      3: thr_of = `TMAM_THR_125;
      4: thr_of = `TMAM_THR_140;
      5: thr_of = `TMAM_THR_155;
      default: thr_of = `TMAM_THR_SD;
    endcase
  endfunction : thr_of

  // True for select codes that route a real source to the pin.
  function automatic logic sel_is_source(input logic [4:0] sel);
    sel_is_source = (sel != `TMAM_SEL_HIZ) && (sel <= `TMAM_SEL_LAST_SRC);
  endfunction : sel_is_source

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [13:0] ctrl_reg;
  logic [5:0] flag_reg;
  logic [5:0] flag_next;
  logic [5:0] mask_reg;
  logic [5:0] sense_d_reg;
  logic [31:0] rdata_reg;
  logic irq_reg;
  logic shutdown_reg;
  logic monitor_power_reg;
  logic mux_drive_reg;
  logic mux_pulldown_reg;
  logic [4:0] mux_source_reg;
  logic mux_div_reg;
  tmam_samp_state_t samp_state_reg;
  tmam_samp_state_t samp_state_next;
  logic [16:0] samp_cnt_reg;
  logic [6:0] db_state;
  logic [6:0] raw_cmp;
  logic mon_en;
  logic mon_aon;
  logic analog_mux_enable;
  logic [4:0] analog_mux_output_sel;
  logic mon_active;
  logic wr_ctrl;
  logic wr_flag;
  logic wr_mask;

  assign mon_en = ctrl_reg[`TMAM_CTRL_MON_EN];
  assign mon_aon = ctrl_reg[`TMAM_CTRL_AON];
  assign analog_mux_enable = ctrl_reg[`TMAM_CTRL_ANALOG_MUX_ENABLE];
  assign analog_mux_output_sel = ctrl_reg[`TMAM_CTRL_SEL_MSB:`TMAM_CTRL_SEL_LSB];

  // Write decode; a frozen clock enable also freezes the bus.
  assign wr_ctrl = clk_en && reg_wr && (reg_addr == `TMAM_ADDR_CTRL);
  assign wr_flag = clk_en && reg_wr && (reg_addr == `TMAM_ADDR_FLAG);
  assign wr_mask = clk_en && reg_wr && (reg_addr == `TMAM_ADDR_MASK);

  // Control register: monitor enable, always-on, mux enable and select.
  always_ff @(posedge core_clk)
  begin
    if (rst)
      ctrl_reg <= `TMAM_CTRL_RST;
    else if (wr_ctrl)
      ctrl_reg <= reg_wdata[13:0] & `TMAM_CTRL_WMASK; // Reserved bits stay 0.
  end

  // Mask register; a set bit keeps its flag off the interrupt line.
  always_ff @(posedge core_clk)
  begin
    if (rst)
      mask_reg <= `TMAM_MASK_RST;
    else if (wr_mask)
      mask_reg <= reg_wdata[5:0];
  end

  // Flags latch on a rising sense edge and clear on write-one; set wins.
  always_comb
  begin
    flag_next = flag_reg;
    if (wr_flag)
      flag_next = flag_next & ~reg_wdata[5:0];
    flag_next = flag_next | (db_state[5:0] & ~sense_d_reg);
  end

  // Flag and previous-sense storage.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      flag_reg <= 6'h00;
      sense_d_reg <= 6'h00;
    end
    else if (clk_en)
    begin
      flag_reg <= flag_next;
      sense_d_reg <= db_state[5:0];
    end
  end

  // Interrupt output, high while any unmasked flag is set.
  always_ff @(posedge core_clk)
  begin
    if (rst)
      irq_reg <= 1'b0;
    else if (clk_en)
      irq_reg <= |(flag_reg & ~mask_reg);
  end

  // Read data, valid in the cycle after the read strobe only.
  always_ff @(posedge core_clk)
  begin
    if (rst)
      rdata_reg <= 32'h0000_0000;
    else if (clk_en)
    begin
      rdata_reg <= 32'h0000_0000;
      if (reg_rd)
      begin
        case (reg_addr)
          `TMAM_ADDR_CTRL: rdata_reg <= {18'h0_0000, ctrl_reg};
          `TMAM_ADDR_FLAG: rdata_reg <= {26'h000_0000, flag_reg};
          `TMAM_ADDR_MASK: rdata_reg <= {26'h000_0000, mask_reg};
          `TMAM_ADDR_SENSE: rdata_reg <= {25'h000_0000, db_state};
          default: rdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Sampling sequencer
  // ----------------------------------------------------------------------
  // Window then wait, repeating every interval while enabled.
  always_comb
  begin
    samp_state_next = samp_state_reg;
    case (samp_state_reg)
      SAMP_IDLE:
        samp_state_next = SAMP_WINDOW;
      SAMP_WINDOW:
        if (samp_cnt_reg == 17'(SAMPLE_WINDOW_CYC - 1))
          samp_state_next = SAMP_WAIT;
      SAMP_WAIT:
        if (samp_cnt_reg == 17'(SAMPLE_INTERVAL_CYC - 1))
          samp_state_next = SAMP_WINDOW;
      default:
        samp_state_next = SAMP_IDLE;
    endcase
    if (!mon_en)
      samp_state_next = SAMP_IDLE;
  end

  // Sequencer state and period counter.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      samp_state_reg <= SAMP_IDLE;
      samp_cnt_reg <= 17'h0_0000;
    end
    else if (clk_en)
    begin
      samp_state_reg <= samp_state_next;
      if (samp_state_next != SAMP_WAIT && samp_state_next != SAMP_WINDOW)
        samp_cnt_reg <= 17'h0_0000;
      else if (samp_cnt_reg == 17'(SAMPLE_INTERVAL_CYC - 1))
        samp_cnt_reg <= 17'h0_0000;
      else if (samp_state_reg != SAMP_IDLE)
        samp_cnt_reg <= samp_cnt_reg + 17'h0_0001;
    end
  end

  // Monitor power: always-on in run, sampled in run or standby.
  always_comb
  begin
    mon_active = 1'b0;
    if (!mon_en)
      mon_active = 1'b0;
    else if (run_state)
      mon_active = mon_aon || (samp_state_reg == SAMP_WINDOW);
    else if (standby_state)
      mon_active = (samp_state_reg == SAMP_WINDOW);
  end

  // Registered power request to the sensor.
  always_ff @(posedge core_clk)
  begin
    if (rst)
      monitor_power_reg <= 1'b0;
    else if (clk_en)
      monitor_power_reg <= mon_active;
  end

  // ----------------------------------------------------------------------
  // Comparators with hysteresis and debounce
  // ----------------------------------------------------------------------
  // Only the centre sensor feeds the comparators.
  generate
    for (genvar k = 0; k < 7; k++)
    begin : gen_cmp
      localparam logic [7:0] THR = thr_of(k);
      localparam logic [7:0] HYS = (k == 6) ? `TMAM_SD_HYS : `TMAM_WARN_HYS;
      localparam logic [7:0] REL = THR - HYS;
      logic stable_reg;
      logic [7:0] cnt_reg;
      // Once tripped, stay tripped until at or below the release point.
      assign raw_cmp[k] = stable_reg ? (temp_center > REL)
                                     : (temp_center >= THR);
      assign db_state[k] = stable_reg;

      // A change must persist for the whole debounce time to be taken.
      always_ff @(posedge core_clk)
      begin
        if (rst)
        begin
          stable_reg <= 1'b0;
          cnt_reg <= 8'h00;
        end
        else if (clk_en)
        begin
          if (!mon_en)
          begin
            stable_reg <= 1'b0;
            cnt_reg <= 8'h00;
          end
          else if (!mon_active || raw_cmp[k] == stable_reg)
            cnt_reg <= 8'h00;
          else if (cnt_reg == 8'(`TMAM_DEBOUNCE_CYC - 1))
          begin
            stable_reg <= raw_cmp[k];
            cnt_reg <= 8'h00;
          end
          else
            cnt_reg <= cnt_reg + 8'h01;
        end
      end
    end
  endgenerate

  // Shutdown request follows the debounced shutdown comparator.
  always_ff @(posedge core_clk)
  begin
    if (rst)
      shutdown_reg <= 1'b0;
    else if (clk_en)
      shutdown_reg <= db_state[`TMAM_SENSE_SHUTDOWN];
  end

  // ----------------------------------------------------------------------
  // Analog mux select
  // ----------------------------------------------------------------------
  // Pin drive, pull-down, routed code and divider choice; zero floats.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      mux_drive_reg <= 1'b0;
      mux_pulldown_reg <= 1'b1;
      mux_source_reg <= `TMAM_SEL_HIZ;
      mux_div_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      mux_drive_reg <= 1'b0;
      mux_pulldown_reg <= 1'b0;
      mux_source_reg <= `TMAM_SEL_HIZ;
      mux_div_reg <= 1'b0;
      if (!system_on || !analog_mux_enable)
        mux_pulldown_reg <= 1'b1;
      else if (sel_is_source(analog_mux_output_sel))
      begin
        mux_drive_reg <= 1'b1;
        mux_source_reg <= analog_mux_output_sel;
        if (analog_mux_output_sel >= `TMAM_SEL_SW_FIRST &&
            analog_mux_output_sel <= `TMAM_SEL_SW_LAST_DIV)
          mux_div_reg <= switcher_at_1v8[3'(analog_mux_output_sel - 5'h04)];
      end
    end
  end

  assign reg_rdata = rdata_reg;
  assign irq = irq_reg;
  assign thermal_shutdown = shutdown_reg;
  assign monitor_power = monitor_power_reg;
  assign analog_mux_drive = mux_drive_reg;
  assign analog_mux_pulldown = mux_pulldown_reg;
  assign analog_mux_source = mux_source_reg;
  assign analog_mux_div_125 = mux_div_reg;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst || !clk_en);

  a_irq_mask_gate: assert property (
    ##1 $past(clk_en) |-> irq_reg == $past(|(flag_reg & ~mask_reg)))
    else $error("interrupt does not follow unmasked flags");
  a_flag_on_rise: assert property (
    $rose(db_state[0]) |=> flag_reg[0])
    else $error("80 degree flag not set on rising sense");
  a_flag_sticky: assert property (
    flag_reg[2] && !wr_flag |=> flag_reg[2])
    else $error("flag dropped without a clear");
  a_debounce_time: assert property (
    $changed(db_state[3]) && mon_en |->
      $past(gen_cmp[3].cnt_reg) == 8'(`TMAM_DEBOUNCE_CYC - 1))
    else $error("sense changed before debounce elapsed");
  a_hyst_release: assert property (
    $fell(db_state[0]) && $past(mon_en) |->
      $past(temp_center) <= (`TMAM_THR_80 - `TMAM_WARN_HYS))
    else $error("sense released above the hysteresis point");
  a_shutdown_hold: assert property (
    shutdown_reg && mon_en && temp_center > 8'h96 |=> shutdown_reg)
    else $error("shutdown released before cooling");
  a_monitor_off: assert property (
    !mon_en |=> !monitor_power_reg && db_state == 7'h00)
    else $error("monitor active while disabled");
  a_aon_power: assert property (
    run_state && mon_en && mon_aon |=> monitor_power_reg)
    else $error("always-on monitor not powered");
  a_standby_sample: assert property (
    !run_state && standby_state && mon_en |=>
      monitor_power_reg == ($past(samp_state_reg) == SAMP_WINDOW))
    else $error("standby monitor not in sampling mode");
  a_mux_pulldown: assert property (
    !analog_mux_enable |=> analog_mux_pulldown && !analog_mux_drive)
    else $error("disabled mux not pulled down");
  a_mux_hiz: assert property (
    analog_mux_enable && system_on && analog_mux_output_sel == 5'h00 |=>
      !analog_mux_pulldown && !analog_mux_drive)
    else $error("select zero not high impedance");
  a_div_ratio: assert property (
    analog_mux_enable && system_on && analog_mux_output_sel == 5'h04 |=>
      analog_mux_div_125 == $past(switcher_at_1v8[0]))
    else $error("switcher one divider wrong");

  c_shutdown: cover property ($rose(shutdown_reg));
  c_irq: cover property ($rose(irq_reg));
  c_window: cover property ($rose(samp_state_reg == SAMP_WINDOW));
  c_mux_src: cover property (analog_mux_drive && analog_mux_source == 5'h18);

endmodule : tmam_top

/* File: rtl/tmam_defs.svh */
// Constants for the thermal monitor and analog mux select block.
`ifndef TMAM_DEFS_SVH
`define TMAM_DEFS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define TMAM_CLK_MHZ 25
`define TMAM_DEBOUNCE_US 10
`define TMAM_DEBOUNCE_CYC (`TMAM_DEBOUNCE_US * `TMAM_CLK_MHZ)
`define TMAM_SAMPLE_INTERVAL_US 3000
`define TMAM_SAMPLE_WINDOW_US 450
`define TMAM_SAMPLE_INTERVAL_CYC (`TMAM_SAMPLE_INTERVAL_US * `TMAM_CLK_MHZ)
`define TMAM_SAMPLE_WINDOW_CYC (`TMAM_SAMPLE_WINDOW_US * `TMAM_CLK_MHZ)

// ----------------------------------------------------------------------
// Register offsets and reset values
// ----------------------------------------------------------------------
`define TMAM_ADDR_CTRL 8'h00
`define TMAM_ADDR_FLAG 8'h04
`define TMAM_ADDR_MASK 8'h08
`define TMAM_ADDR_SENSE 8'h0C
`define TMAM_CTRL_RST 14'h0001
`define TMAM_CTRL_WMASK 14'h1F07
`define TMAM_MASK_RST 6'h3F

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TMAM_CTRL_MON_EN 0
`define TMAM_CTRL_AON 1
`define TMAM_CTRL_ANALOG_MUX_ENABLE 2
`define TMAM_CTRL_SEL_LSB 8
`define TMAM_CTRL_SEL_MSB 12
`define TMAM_SENSE_SHUTDOWN 6

// ----------------------------------------------------------------------
// Thresholds in degrees Celsius
// ----------------------------------------------------------------------
`define TMAM_THR_80 8'h50
`define TMAM_THR_95 8'h5F
`define TMAM_THR_110 8'h6E
`define TMAM_THR_125 8'h7D
`define TMAM_THR_140 8'h8C
`define TMAM_THR_155 8'h9B
`define TMAM_THR_SD 8'hA5
`define TMAM_WARN_HYS 8'h05
`define TMAM_SD_HYS 8'h0F

// ----------------------------------------------------------------------
// Mux select codes
// ----------------------------------------------------------------------
`define TMAM_SEL_HIZ 5'h00
`define TMAM_SEL_LAST_SRC 5'h18
`define TMAM_SEL_SW_FIRST 5'h04
`define TMAM_SEL_SW_LAST_DIV 5'h09

`endif

/* File: rtl/tmam_pkg.sv */
// Types for the thermal monitor and analog mux select block.
package tmam_pkg;

  // Sampling sequencer states.
  typedef enum logic [1:0] {
    SAMP_IDLE = 2'b00,
    SAMP_WINDOW = 2'b01,
    SAMP_WAIT = 2'b10
  } tmam_samp_state_t;

  // Number of warning thresholds.
  localparam int TMAM_NUM_WARN = 6;

endpackage : tmam_pkg

/* File: test/tb.sv */
// Self-checking testbench for the thermal monitor and analog mux block.
`timescale 1ns/1ps
`include "tmam_defs.svh"

module tb;
  import tmam_pkg::*;

  // ----------------------------------------------------------------------
  // Clock, reset and stimulus signals
  // ----------------------------------------------------------------------
  localparam int LIMIT = 20000;
  localparam int PER = 40;
  localparam int WIN = 10;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [7:0] temp_center = 8'h00;
  logic run_state = 1'b1;
  logic standby_state = 1'b0;
  logic system_on = 1'b1;
  logic [5:0] sw18 = 6'h25;
  logic irq, thermal_shutdown, monitor_power;
  logic mux_drv, mux_pull, mux_div;
  logic [4:0] mux_src;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  int i;
  int n;

  // The clock toggles every half period of 20 ns.
  always #20 core_clk = ~core_clk;

  tmam_top #(
    .SAMPLE_INTERVAL_CYC(PER),
    .SAMPLE_WINDOW_CYC(WIN)
  ) dut_u (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .temp_center(temp_center),
    .run_state(run_state),
    .standby_state(standby_state),
    .system_on(system_on),
    .switcher_at_1v8(sw18),
    .irq(irq),
    .thermal_shutdown(thermal_shutdown),
    .monitor_power(monitor_power),
    .analog_mux_drive(mux_drv),
    .analog_mux_pulldown(mux_pull),
    .analog_mux_source(mux_src),
    .analog_mux_div_125(mux_div)
  );

  // ----------------------------------------------------------------------
  // Bus, wait and compare tasks
  // ----------------------------------------------------------------------
  // One-cycle write strobe beside address and data.
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr_reg

  // One-cycle read strobe; the data stand only in the following cycle.
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd_reg

  // Waits a number of edges and samples just after the last one.
  task automatic wait_cyc(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask : wait_cyc

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_cnt(input int got, input int exp);
    tests_run++;
    if (got != exp)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_cnt

  // Reads one register and compares it.
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd_reg(a, d);
    chk_reg(d, exp);
  endtask : rd_chk

  // Counts the cycles with the sensor powered over a span of c cycles.
  task automatic count_power(input int c, output int k);
    k = 0;
    repeat (c)
    begin
      @(posedge core_clk);
      #1;
      if (monitor_power === 1'b1)
        k++;
    end
  endtask : count_power

  // Prints the counts and the verdict, then ends the run.
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  // A hang is cut short by a cycle ceiling counted as a mismatch.
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      fails++;
      results();
    end
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    wait_cyc(1);
    chk_bit(mux_pull, 1'b1);
    chk_bit(irq, 1'b0);
    rd_chk(`TMAM_ADDR_CTRL, 32'h0000_0001);
    rd_chk(`TMAM_ADDR_MASK, 32'h0000_003F);
    rd_chk(`TMAM_ADDR_FLAG, 32'h0000_0000);
    rd_chk(8'h10, 32'h0000_0000);
    // Strobes with the clock enable low must be ignored.
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr_reg(`TMAM_ADDR_MASK, 32'h0000_0000);
    clk_en <= 1'b1;
    rd_chk(`TMAM_ADDR_MASK, 32'h0000_003F);
    // Only the defined control bits can be written; the rest read 0.
    wr_reg(`TMAM_ADDR_CTRL, 32'hFFFF_E0F8);
    rd_chk(`TMAM_ADDR_CTRL, 32'h0000_0000);
    // Every select code with the mux enabled and the system on.
    for (i = 0; i < 32; i++)
    begin
      wr_reg(`TMAM_ADDR_CTRL, 32'h0000_0004 | (32'(i) << 8));
      wait_cyc(2);
      n = (i >= 1 && i <= 24) ? 1 : 0;
      chk_bit(mux_drv, n[0]);
      chk_bit(mux_pull, 1'b0);
      chk_reg({27'd0, mux_src}, n ? 32'(i) : 32'd0);
      if (i >= 4 && i <= 9)
        chk_bit(mux_div, sw18[i - 4]);
      else
        chk_bit(mux_div, 1'b0);
    end
    wr_reg(`TMAM_ADDR_CTRL, 32'h0000_0500);
    wait_cyc(2);
    chk_bit(mux_pull, 1'b1);
    chk_bit(mux_drv, 1'b0);
    wr_reg(`TMAM_ADDR_CTRL, 32'h0000_0504);
    system_on <= 1'b0;
    wait_cyc(3);
    chk_bit(mux_drv, 1'b0);
    chk_bit(mux_pull, 1'b1);
    system_on <= 1'b1;
    // Always-on monitor in run; unmask only the lowest threshold.
    wr_reg(`TMAM_ADDR_MASK, 32'h0000_003E);
    wr_reg(`TMAM_ADDR_CTRL, 32'h0000_0003);
    count_power(400, n);
    chk_cnt(n, 400);
    temp_center <= 8'd80;
    wait_cyc(100);
    temp_center <= 8'd70;
    wait_cyc(300);
    rd_chk(`TMAM_ADDR_SENSE, 32'h0000_0000);
    temp_center <= 8'd80;
    wait_cyc(260);
    rd_chk(`TMAM_ADDR_SENSE, 32'h0000_0001);
    rd_chk(`TMAM_ADDR_FLAG, 32'h0000_0001);
    chk_bit(irq, 1'b1);
    temp_center <= 8'd76;
    wait_cyc(300);
    rd_chk(`TMAM_ADDR_SENSE, 32'h0000_0001);
    temp_center <= 8'd75;
    wait_cyc(260);
    rd_chk(`TMAM_ADDR_SENSE, 32'h0000_0000);
    rd_chk(`TMAM_ADDR_FLAG, 32'h0000_0001);
    wr_reg(`TMAM_ADDR_FLAG, 32'h0000_0001);
    wait_cyc(2);
    chk_bit(irq, 1'b0);
    rd_chk(`TMAM_ADDR_FLAG, 32'h0000_0000);
    // A masked threshold sets its flag but leaves the interrupt low.
    temp_center <= 8'd95;
    wait_cyc(260);
    rd_chk(`TMAM_ADDR_FLAG, 32'h0000_0003);
    wr_reg(`TMAM_ADDR_FLAG, 32'h0000_0001);
    wait_cyc(3);
    chk_bit(irq, 1'b0);
    // Shutdown trip and its hysteresis.
    temp_center <= 8'd200;
    wait_cyc(260);
    rd_chk(`TMAM_ADDR_SENSE, 32'h0000_007F);
    // The 80 degree sense never fell after its clear, so no new flag.
    rd_chk(`TMAM_ADDR_FLAG, 32'h0000_003E);
    chk_bit(thermal_shutdown, 1'b1);
    temp_center <= 8'd151;
    wait_cyc(300);
    chk_bit(thermal_shutdown, 1'b1);
    temp_center <= 8'd150;
    wait_cyc(260);
    chk_bit(thermal_shutdown, 1'b0);
    // Disabling the monitor drops senses, shutdown and sensor power.
    temp_center <= 8'd200;
    wait_cyc(260);
    chk_bit(thermal_shutdown, 1'b1);
    wr_reg(`TMAM_ADDR_CTRL, 32'h0000_0000);
    wait_cyc(3);
    chk_bit(thermal_shutdown, 1'b0);
    rd_chk(`TMAM_ADDR_SENSE, 32'h0000_0000);
    count_power(400, n);
    chk_cnt(n, 0);
    // Sampling mode in run, then standby with always-on ignored.
    wr_reg(`TMAM_ADDR_CTRL, 32'h0000_0001);
    wait_cyc(50);
    count_power(400, n);
    chk_cnt(n, 400 / PER * WIN);
    run_state <= 1'b0;
    standby_state <= 1'b1;
    wr_reg(`TMAM_ADDR_CTRL, 32'h0000_0003);
    wait_cyc(50);
    count_power(400, n);
    chk_cnt(n, 400 / PER * WIN);
    wr_reg(`TMAM_ADDR_CTRL, 32'h0000_0002);
    wait_cyc(5);
    count_power(400, n);
    chk_cnt(n, 0);
    results();
  end
endmodule : tb
